// File: src/fbw_block_window.sv
// Block window, checksum commit and key-based security modes.
// Assumes one command per cycle from the host interface logic.
module fbw_block_window (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_wr,
    input  wire logic       cmd_rd,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_wdata,
    output logic [7:0]      cmd_rdata,
    output logic            busy,
    output logic            sealed_flag,
    output logic            full_access_flag,
    output logic            commit_ok,
    output logic            commit_err
);
    localparam int AW = 8 + fbw_pkg::BLK_W + fbw_pkg::OFF_W;
    localparam logic [fbw_pkg::CNT_W-1:0] CNT_END = fbw_pkg::CNT_W'(32);
    localparam logic [fbw_pkg::CNT_W-1:0] CNT_ONE = fbw_pkg::CNT_W'(1);

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Complement of the 8-bit sum of the window
    function automatic logic [7:0] csum_of(input logic [31:0][7:0] w);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < fbw_pkg::WIN_BYTES; i++) begin
            s = s + w[i];
        end
        return ~s;
    endfunction : csum_of

    // Window location to byte offset
    function automatic logic [4:0] win_idx(input logic [7:0] a);
        return a[fbw_pkg::OFF_W-1:0];
    endfunction : win_idx

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    fbw_pkg::fbw_mode_e mode_q, mode_d;
    fbw_pkg::fbw_fsm_e  fsm_q, fsm_d;
    fbw_pkg::fbw_key_e  pend_q, pend_d;
    logic [31:0][7:0] win_q, win_d;
    logic [31:0]      mask_q, mask_d;
    logic [7:0]  class_q, class_d, block_q, block_d, acc_q, acc_d;
    logic [7:0]  csum_q, csum_d, ctl_lo_q, ctl_lo_d, info_q, info_d;
    logic [7:0]  row_cls_q, row_cls_d;
    logic [fbw_pkg::BLK_W-1:0] row_blk_q, row_blk_d;
    logic [fbw_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        ok_q, ok_d, err_q, err_d, seal_q, seal_d, full_q, full_d;
    logic        busy_q, busy_d;
    logic [AW-1:0] nv_rd_addr, nv_wr_addr;
    logic [7:0]  nv_rd_data, nv_wr_data;
    logic        nv_wr_en;
    logic [63:0] keys;
    logic [15:0] ctl_word, uk0, uk1, fk0, fk1;
    logic        info_path, wr_ok, csum_good;

    fbw_nv_store #(.ADDR_W(AW)) u_nv (
        .clk       (clk),
        .rd_addr   (nv_rd_addr),
        .rd_data   (nv_rd_data),
        .wr_en     (nv_wr_en),
        .wr_addr   (nv_wr_addr),
        .wr_data   (nv_wr_data),
        .key_bytes (keys)
    );

    // Expected control words keep read-back order: lower-offset key byte in the low half
    assign uk0 = {keys[15:8], keys[7:0]};
    assign uk1 = {keys[31:24], keys[23:16]};
    assign fk0 = {keys[47:40], keys[39:32]};
    assign fk1 = {keys[63:56], keys[55:48]};
    assign ctl_word = {cmd_wdata, ctl_lo_q};
    assign info_path = (mode_q == fbw_pkg::FBW_SEALED) ||
                       (acc_q == fbw_pkg::ACC_INFO);
    assign csum_good = (cmd_wdata == csum_of(win_q));

    // Commit permission for the row held in the window
    always_comb begin
        wr_ok = 1'b0;
        case (mode_q)
            fbw_pkg::FBW_SEALED: begin
                wr_ok = (info_q > fbw_pkg::INFO_A) &&
                        (info_q <= fbw_pkg::INFO_C);
            end
            fbw_pkg::FBW_UNLOCKED: begin
                wr_ok = info_path ? ((info_q >= fbw_pkg::INFO_A) &&
                                     (info_q <= fbw_pkg::INFO_C))
                        : (row_cls_q != fbw_pkg::KEY_CLASS);
            end
            fbw_pkg::FBW_FULL: begin
                wr_ok = !info_path || ((info_q >= fbw_pkg::INFO_A) &&
                                       (info_q <= fbw_pkg::INFO_C));
            end
            default: wr_ok = 1'b0;
        endcase
    end

    //------------------------------------------------------------
    // Next state
    //------------------------------------------------------------
    always_comb begin
        mode_d = mode_q; fsm_d = fsm_q; pend_d = pend_q;
        win_d = win_q; mask_d = mask_q; class_d = class_q;
        block_d = block_q; acc_d = acc_q; csum_d = csum_q;
        ctl_lo_d = ctl_lo_q; info_d = info_q; row_cls_d = row_cls_q;
        row_blk_d = row_blk_q; cnt_d = cnt_q; rdata_d = rdata_q;
        ok_d = 1'b0; err_d = 1'b0;
        nv_wr_en = 1'b0;
        nv_rd_addr = {row_cls_q, row_blk_q, cnt_q[fbw_pkg::OFF_W-1:0]};
        nv_wr_addr = nv_rd_addr;
        nv_wr_data = win_q[cnt_q[fbw_pkg::OFF_W-1:0]];
        case (fsm_q)
            fbw_pkg::FBW_IDLE: begin
                if (cmd_wr && mode_q != fbw_pkg::FBW_BOOT_ROM) begin
                    if (cmd_addr == fbw_pkg::CMD_CTL_LO) begin
                        ctl_lo_d = cmd_wdata;
                    end else if (cmd_addr == fbw_pkg::CMD_CTL_HI) begin
                        pend_d = fbw_pkg::KEY_NONE;
                        if (pend_q == fbw_pkg::KEY_UNLOCK && ctl_word == uk1
                            && mode_q == fbw_pkg::FBW_SEALED) begin
                            mode_d = fbw_pkg::FBW_UNLOCKED;
                        end else if (pend_q == fbw_pkg::KEY_FULL &&
                                     ctl_word == fk1 &&
                                     mode_q == fbw_pkg::FBW_UNLOCKED) begin
                            mode_d = fbw_pkg::FBW_FULL;
                        end else if (ctl_word == fbw_pkg::SUB_SEAL) begin
                            mode_d = fbw_pkg::FBW_SEALED;
                        end else if (ctl_word == fbw_pkg::SUB_ROM &&
                                     mode_q == fbw_pkg::FBW_FULL) begin
                            mode_d = fbw_pkg::FBW_BOOT_ROM;
                        end else if (mode_q == fbw_pkg::FBW_SEALED &&
                                     ctl_word == uk0) begin
                            pend_d = fbw_pkg::KEY_UNLOCK;
                        end else if (mode_q == fbw_pkg::FBW_UNLOCKED &&
                                     ctl_word == fk0) begin
                            pend_d = fbw_pkg::KEY_FULL;
                        end
                    end else if (cmd_addr == fbw_pkg::CMD_CLASS) begin
                        if (mode_q != fbw_pkg::FBW_SEALED) begin
                            class_d = cmd_wdata;
                        end
                    end else if (cmd_addr == fbw_pkg::CMD_ACCESS) begin
                        if (mode_q != fbw_pkg::FBW_SEALED) begin
                            acc_d = cmd_wdata;
                        end
                    end else if (cmd_addr == fbw_pkg::CMD_BLOCK) begin
                        block_d = cmd_wdata;
                        info_d = cmd_wdata;
                        if (!info_path) begin
                            row_cls_d = class_q;
                            row_blk_d = cmd_wdata[fbw_pkg::BLK_W-1:0];
                            fsm_d = fbw_pkg::FBW_LOAD;
                        end else if (cmd_wdata >= fbw_pkg::INFO_A &&
                                     cmd_wdata <= fbw_pkg::INFO_C) begin
                            row_cls_d = fbw_pkg::INFO_CLASS;
                            row_blk_d = fbw_pkg::BLK_W'(cmd_wdata -
                                                         fbw_pkg::INFO_A);
                            fsm_d = fbw_pkg::FBW_LOAD;
                        end
                        cnt_d = '0;
                        mask_d = '0;
                    end else if (cmd_addr >= fbw_pkg::CMD_WIN_BASE &&
                                 cmd_addr <= fbw_pkg::CMD_WIN_LAST) begin
                        win_d[win_idx(cmd_addr)] = cmd_wdata;
                        mask_d[win_idx(cmd_addr)] = 1'b1;
                    end else if (cmd_addr == fbw_pkg::CMD_CSUM) begin
                        csum_d = cmd_wdata;
                        if (csum_good && wr_ok) begin
                            fsm_d = fbw_pkg::FBW_COMMIT;
                            cnt_d = '0;
                            ok_d = 1'b1;
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                end
            end
            fbw_pkg::FBW_LOAD: begin
                if (cnt_q != '0) begin
                    win_d[5'(cnt_q - CNT_ONE)] = nv_rd_data;
                end
                cnt_d = cnt_q + CNT_ONE;
                if (cnt_q == CNT_END) begin
                    fsm_d = fbw_pkg::FBW_IDLE;
                end
            end
            fbw_pkg::FBW_COMMIT: begin
                nv_wr_en = mask_q[cnt_q[fbw_pkg::OFF_W-1:0]];
                cnt_d = cnt_q + CNT_ONE;
                if (cnt_q == CNT_END - CNT_ONE) begin
                    fsm_d = fbw_pkg::FBW_IDLE;
                end
            end
            default: fsm_d = fbw_pkg::FBW_IDLE;
        endcase
        // Read answers
        if (cmd_rd) begin
            rdata_d = fbw_pkg::BYTE_ZERO;
            if (mode_q == fbw_pkg::FBW_BOOT_ROM) begin
                rdata_d = fbw_pkg::BYTE_ZERO;
            end else if (cmd_addr >= fbw_pkg::CMD_WIN_BASE &&
                         cmd_addr <= fbw_pkg::CMD_WIN_LAST) begin
                rdata_d = win_q[win_idx(cmd_addr)];
            end else if (cmd_addr == fbw_pkg::CMD_CTL_HI) begin
                rdata_d[fbw_pkg::STAT_SEAL_BIT] = seal_q;
                rdata_d[fbw_pkg::STAT_FULL_BIT] = full_q;
            end else if (cmd_addr == fbw_pkg::CMD_BLOCK) begin
                rdata_d = block_q;
            end else if (cmd_addr == fbw_pkg::CMD_CSUM) begin
                rdata_d = csum_q;
            end else if (mode_q != fbw_pkg::FBW_SEALED) begin
                if (cmd_addr == fbw_pkg::CMD_CLASS) begin
                    rdata_d = class_q;
                end else if (cmd_addr == fbw_pkg::CMD_ACCESS) begin
                    rdata_d = acc_q;
                end
            end
        end
        seal_d = (mode_d == fbw_pkg::FBW_SEALED);
        full_d = (mode_d != fbw_pkg::FBW_FULL);
        busy_d = (fsm_d != fbw_pkg::FBW_IDLE);
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= fbw_pkg::FBW_SEALED;
            fsm_q <= fbw_pkg::FBW_IDLE;
            pend_q <= fbw_pkg::KEY_NONE;
            win_q <= '0; mask_q <= '0; class_q <= '0; block_q <= '0;
            acc_q <= '0; csum_q <= '0; ctl_lo_q <= '0; info_q <= '0;
            row_cls_q <= '0; row_blk_q <= '0; cnt_q <= '0;
            rdata_q <= '0; ok_q <= 1'b0; err_q <= 1'b0;
            seal_q <= 1'b1; full_q <= 1'b1; busy_q <= 1'b0;
        end else begin
            mode_q <= mode_d; fsm_q <= fsm_d; pend_q <= pend_d;
            win_q <= win_d; mask_q <= mask_d; class_q <= class_d;
            block_q <= block_d; acc_q <= acc_d; csum_q <= csum_d;
            ctl_lo_q <= ctl_lo_d; info_q <= info_d;
            row_cls_q <= row_cls_d; row_blk_q <= row_blk_d; cnt_q <= cnt_d;
            rdata_q <= rdata_d; ok_q <= ok_d; err_q <= err_d;
            seal_q <= seal_d; full_q <= full_d; busy_q <= busy_d;
        end
    end

    assign cmd_rdata = rdata_q;
    assign busy = busy_q;
    assign sealed_flag = seal_q;
    assign full_access_flag = full_q;
    assign commit_ok = ok_q;
    assign commit_err = err_q;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    unseal_keys_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr &&
        cmd_addr == fbw_pkg::CMD_CTL_HI && pend_q == fbw_pkg::KEY_UNLOCK &&
        mode_q == fbw_pkg::FBW_SEALED && ctl_word == uk1
        |=> !sealed_flag && full_access_flag)
        else $error("unlock key pair did not clear sealed flag");
    full_keys_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr &&
        cmd_addr == fbw_pkg::CMD_CTL_HI && pend_q == fbw_pkg::KEY_FULL &&
        mode_q == fbw_pkg::FBW_UNLOCKED && ctl_word == fk1
        |=> !full_access_flag)
        else $error("full access key pair did not clear flag");
    key_break_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr && pend_q != fbw_pkg::KEY_NONE
        && cmd_addr == fbw_pkg::CMD_CTL_HI && ctl_word != uk1 &&
        ctl_word != fk1 && ctl_word != fbw_pkg::SUB_SEAL &&
        ctl_word != fbw_pkg::SUB_ROM |=> $stable(mode_q))
        else $error("broken key sequence changed mode");
    commit_len_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr && cmd_addr == fbw_pkg::CMD_CSUM
        && csum_good && wr_ok |=> commit_ok && busy ##31 busy ##1 !busy)
        else $error("good checksum commit did not last 32 cycles");
    bad_csum_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr && cmd_addr == fbw_pkg::CMD_CSUM
        && !csum_good |=> commit_err && !busy && $stable(win_q))
        else $error("bad checksum started a commit");
    info_a_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
        nv_wr_en && mode_q == fbw_pkg::FBW_SEALED
        |-> row_cls_q == fbw_pkg::INFO_CLASS && row_blk_q != '0)
        else $error("sealed write reached information block A");
    key_update_a: assert property (@(posedge clk) disable iff (sys_rst)
        nv_wr_en && row_cls_q == fbw_pkg::KEY_CLASS && !info_path
        |-> mode_q == fbw_pkg::FBW_FULL)
        else $error("key class written outside full access");
    sealed_class_a: assert property (@(posedge clk) disable iff (sys_rst)
        mode_q == fbw_pkg::FBW_SEALED && cmd_wr &&
        cmd_addr == fbw_pkg::CMD_CLASS |=> $stable(class_q))
        else $error("sealed class write was taken");
    info_load_a: assert property (@(posedge clk) disable iff (sys_rst)
        fsm_q == fbw_pkg::FBW_IDLE && cmd_wr && info_path &&
        mode_q != fbw_pkg::FBW_BOOT_ROM && cmd_addr == fbw_pkg::CMD_BLOCK
        && cmd_wdata == 8'h02 |=> row_cls_q == fbw_pkg::INFO_CLASS &&
        row_blk_q == 2'h1 ##33 !busy)
        else $error("information block B not loaded");
    rom_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        mode_q == fbw_pkg::FBW_BOOT_ROM && cmd_rd |=> cmd_rdata == 8'h00)
        else $error("boot ROM mode returned data");
endmodule : fbw_block_window

// File: inc/fbw_pkg.sv
// Constants and types for the block-window access and security block.
// Assumes a single system clock and a byte-wide host command port.
package fbw_pkg;
    //------------------------------------------------------------
    // Command codes
    //------------------------------------------------------------
    localparam logic [7:0] CMD_CTL_LO   = 8'h00;
    localparam logic [7:0] CMD_CTL_HI   = 8'h01;
    localparam logic [7:0] CMD_CLASS    = 8'h3E;
    localparam logic [7:0] CMD_BLOCK    = 8'h3F;
    localparam logic [7:0] CMD_WIN_BASE = 8'h40;
    localparam logic [7:0] CMD_WIN_LAST = 8'h5F;
    localparam logic [7:0] CMD_CSUM     = 8'h60;
    localparam logic [7:0] CMD_ACCESS   = 8'h61;
    //------------------------------------------------------------
    // Field values and memory layout
    //------------------------------------------------------------
    localparam logic [7:0] ACC_GENERAL  = 8'h00;
    localparam logic [7:0] ACC_INFO     = 8'h01;
    localparam logic [7:0] INFO_A       = 8'h01;
    localparam logic [7:0] INFO_C       = 8'h03;
    localparam logic [7:0] INFO_CLASS   = 8'h3A;
    localparam logic [7:0] KEY_CLASS    = 8'h70;
    localparam logic [15:0] SUB_SEAL    = 16'h0020;
    localparam logic [15:0] SUB_ROM     = 16'h0F00;
    localparam int WIN_BYTES  = 32;
    localparam int OFF_W      = 5;
    localparam int BLK_W      = 2;
    localparam int CNT_W      = 6;
    localparam int STAT_SEAL_BIT = 5;
    localparam int STAT_FULL_BIT = 6;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Factory key row, byte 0 in the low bits; the value is arbitrary
    localparam logic [63:0] KEY_INIT = 64'h8877_6655_4433_2211;
    //------------------------------------------------------------
    // Types
    //------------------------------------------------------------
    typedef enum logic [1:0] {
        FBW_FULL, FBW_UNLOCKED, FBW_SEALED, FBW_BOOT_ROM
    } fbw_mode_e;
    typedef enum logic [1:0] { FBW_IDLE, FBW_LOAD, FBW_COMMIT } fbw_fsm_e;
    typedef enum logic [1:0] { KEY_NONE, KEY_UNLOCK, KEY_FULL } fbw_key_e;
endpackage : fbw_pkg

// File: src/fbw_nv_store.sv
// Non-volatile byte store: one registered read port, one write port.
// Assumes the store keeps its contents through reset (no reset on array).
module fbw_nv_store #(
    parameter int ADDR_W = 8 + fbw_pkg::BLK_W + fbw_pkg::OFF_W
) (
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic [7:0]             rd_data,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [7:0]        wr_data,
    output logic [63:0]            key_bytes
);
    localparam logic [fbw_pkg::BLK_W-1:0] BLK_ZERO = '0;
    logic [7:0] mem [2**ADDR_W];
    logic [7:0] rd_q;

    // Factory key row, so that a fresh part can be unlocked at all
    initial begin
        for (int i = 0; i < 8; i++) begin
            mem[{fbw_pkg::KEY_CLASS, BLK_ZERO, 5'(i)}] =
                fbw_pkg::KEY_INIT[8*i +: 8];
        end
    end

    // Stored as written, no range checks, survives reset
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_q <= mem[rd_addr];
    end
    assign rd_data = rd_q;

    // Key bytes sit at offsets 0..7 of block 0 of the key class
    for (genvar i = 0; i < 8; i++) begin : g_key
        assign key_bytes[8*i +: 8] =
            mem[{fbw_pkg::KEY_CLASS, BLK_ZERO, 5'(i)}];
    end
endmodule : fbw_nv_store

// File: tb/fbw_host.sv
// Host model: byte writes and reads on the block's command port.
// Assumes the bench calls one task at a time; writes wait out busy.
module fbw_host (
    input  wire logic       clk,
    input  wire logic       busy,
    input  wire logic [7:0] cmd_rdata,
    output logic            cmd_wr,
    output logic            cmd_rd,
    output logic [7:0]      cmd_addr,
    output logic [7:0]      cmd_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quiet port at time zero
    initial begin
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
    end
    // Wait, bounded, until no load or commit runs
    task automatic idle();
        repeat (2) @(posedge clk);
        for (int n = 0; n < 50 && busy !== 1'b0; n++) @(posedge clk);
    endtask : idle
    // One write pulse, held across the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        idle();
        cmd_addr  <= a;
        cmd_wdata <= d;
        cmd_wr    <= 1'b1;
        @(posedge clk);
        cmd_wr    <= 1'b0;
    endtask : wr
    // One read pulse; data is registered one cycle on
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        cmd_addr <= a;
        cmd_rd   <= 1'b1;
        @(posedge clk);
        cmd_rd   <= 1'b0;
        #1 q = cmd_rdata;
    endtask : rd
    // Key word in read-back order, low byte then acting high byte
    task automatic key(input logic [15:0] w);
        wr(fbw_pkg::CMD_CTL_LO, w[7:0]);
        wr(fbw_pkg::CMD_CTL_HI, w[15:8]);
    endtask : key
    // Fill all window bytes from seed s and return their checksum
    task automatic fill(input logic [7:0] s, output logic [7:0] c);
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 32; i++) begin
            wr(8'(fbw_pkg::CMD_WIN_BASE + i), 8'(s + 8'(i * 3)));
            sum = 8'(sum + s + 8'(i * 3));
        end
        c = ~sum;
    endtask : fill
endmodule : fbw_host

// File: tb/flash_block_window_security_tb_top.sv
// Bench: sealed-mode window, info block commits, refusals, persistence.
// Assumes the host model drives the command port; bench drives reset.
module flash_block_window_security_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, sys_rst, busy, cmd_wr, cmd_rd, sealed_flag;
    logic       full_access_flag, commit_ok, commit_err;
    logic [7:0] cmd_addr, cmd_wdata, cmd_rdata, q, c;
    int         fails = 0;
    int         checked = 0;
    fbw_block_window DUT (.clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .busy(busy), .sealed_flag(sealed_flag),
        .full_access_flag(full_access_flag), .commit_ok(commit_ok),
        .commit_err(commit_err));
    fbw_host host (.clk(clk), .busy(busy), .cmd_rdata(cmd_rdata),
        .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata));
    // Clock at 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic do_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : do_reset
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit
    // Checksum write, then the result pulses one cycle on
    task automatic commit(input logic [7:0] s, input logic ok);
        host.wr(fbw_pkg::CMD_CSUM, s);
        #1;
        chk_bit(commit_ok, ok);
        chk_bit(commit_err, !ok);
    endtask : commit
    task automatic give_verdict();
        $display("Checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        fails++;
        give_verdict();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        do_reset();
        #1;
        chk_bit(sealed_flag, 1'b1);
        chk_bit(full_access_flag, 1'b1);
        host.rd(fbw_pkg::CMD_CTL_HI, q);
        chk_byte(q & 8'h60, 8'h60);
        host.rd(fbw_pkg::CMD_WIN_BASE, q);
        chk_byte(q, 8'h00);
        host.wr(fbw_pkg::CMD_CLASS, 8'h50);
        host.rd(fbw_pkg::CMD_CLASS, q);
        chk_byte(q, 8'h00);
        host.wr(fbw_pkg::CMD_ACCESS, 8'h00);
        host.rd(fbw_pkg::CMD_ACCESS, q);
        chk_byte(q, 8'h00);
        host.key(16'h3412);
        host.key(16'h7856);
        repeat (3) @(posedge clk);
        #1 chk_bit(sealed_flag, 1'b1);
        // Load each info block, fill, bad then good checksum
        for (int b = 1; b <= 3; b++) begin
            host.wr(fbw_pkg::CMD_BLOCK, 8'(b));
            host.fill(8'(b * 40), c);
            host.rd(8'h45, q);
            chk_byte(q, 8'(b * 40 + 15));
            commit(~c, 1'b0);
            host.rd(8'h45, q);
            chk_byte(q, 8'(b * 40 + 15));
            commit(c, b != 1);
        end
        // Second reset: B and C contents must survive it
        host.idle();
        do_reset();
        for (int b = 2; b <= 3; b++) begin
            host.wr(fbw_pkg::CMD_BLOCK, 8'(b));
            host.idle();
            for (int i = 0; i < 32; i++) begin
                host.rd(8'(fbw_pkg::CMD_WIN_BASE + i), q);
                chk_byte(q, 8'(b * 40 + i * 3));
            end
        end
        // Unlock with the factory keys, then the general path
        host.key(fbw_pkg::KEY_INIT[15:0]);
        host.key(fbw_pkg::KEY_INIT[31:16]);
        #1 chk_bit(sealed_flag, 1'b0);
        chk_bit(full_access_flag, 1'b1);
        host.wr(fbw_pkg::CMD_ACCESS, fbw_pkg::ACC_GENERAL);
        host.wr(fbw_pkg::CMD_CLASS, fbw_pkg::KEY_CLASS);
        host.rd(fbw_pkg::CMD_CLASS, q);
        chk_byte(q, fbw_pkg::KEY_CLASS);
        host.wr(fbw_pkg::CMD_BLOCK, 8'h00);
        host.idle();
        for (int i = 0; i < 8; i++) begin
            host.rd(8'(fbw_pkg::CMD_WIN_BASE + i), q);
            chk_byte(q, fbw_pkg::KEY_INIT[8*i +: 8]);
        end
        host.fill(8'h90, c);
        commit(c, 1'b0);
        // Information block B through class 58, block 1
        host.wr(fbw_pkg::CMD_CLASS, fbw_pkg::INFO_CLASS);
        host.wr(fbw_pkg::CMD_BLOCK, 8'h01);
        host.idle();
        host.rd(fbw_pkg::CMD_WIN_LAST, q);
        chk_byte(q, 8'(80 + 31 * 3));
        host.wr(8'h43, 8'hA5);
        c = 8'h00;
        for (int i = 0; i < 32; i++) begin
            c = 8'(c + ((i == 3) ? 8'hA5 : 8'(80 + i * 3)));
        end
        commit(~c, 1'b1);
        host.wr(fbw_pkg::CMD_BLOCK, 8'h01);
        host.idle();
        host.rd(8'h43, q);
        chk_byte(q, 8'hA5);
        host.rd(8'h44, q);
        chk_byte(q, 8'(80 + 4 * 3));
        // Boot ROM refused while unlocked: sealed 0, full flag 1
        host.key(fbw_pkg::SUB_ROM);
        host.rd(fbw_pkg::CMD_CTL_HI, q);
        chk_byte(q, 8'h40);
        // Full access, key update, then boot ROM
        host.key(fbw_pkg::KEY_INIT[47:32]);
        host.key(fbw_pkg::KEY_INIT[63:48]);
        #1 chk_bit(full_access_flag, 1'b0);
        host.wr(fbw_pkg::CMD_CLASS, fbw_pkg::KEY_CLASS);
        host.wr(fbw_pkg::CMD_BLOCK, 8'h00);
        host.fill(8'h90, c);
        commit(c, 1'b1);
        host.key(fbw_pkg::SUB_ROM);
        host.rd(fbw_pkg::CMD_CTL_HI, q);
        chk_byte(q, 8'h00);
        // Reset leaves boot ROM; only the new keys unlock now
        do_reset();
        host.key(16'h9390);
        host.key(16'h9996);
        #1 chk_bit(sealed_flag, 1'b0);
        give_verdict();
    end
endmodule : flash_block_window_security_tb_top
